/* rtl/drs_pkg.sv */
/*
 * Constants, register map and carrier types for the display reset and standby sequencer.
 * Assumes a single 50 MHz main clock; every cycle count below is derived from that period.
 */
package drs_pkg;
	// Main clock period and the nominal period of the reference main clock of the device
	localparam int CLK_PERIOD_NS = 20;
	localparam int MAIN20_PERIOD_NS = 50;
	// Internal reset hold after a source releases, least time
	localparam int RESET_HOLD_US = 4;
	localparam int RESET_HOLD_CYC = (RESET_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Initialisation window with host access locked out
	localparam int INIT_WINDOW_US = 60;
	localparam int INIT_WINDOW_CYC = (INIT_WINDOW_US * 1000) / CLK_PERIOD_NS;
	// Supply must stay low for more than this before power-down asserts
	localparam int PD_FILTER_NS = 50;
	localparam int PD_FILTER_CYC = PD_FILTER_NS / CLK_PERIOD_NS + 1;
	// Power-down extension after the supply is back
	localparam int PD_EXTEND_US = 50;
	localparam int PD_EXTEND_CYC = (PD_EXTEND_US * 1000) / CLK_PERIOD_NS;
	// Reference high phase must last two periods of the 20 MHz clock
	localparam int REL_EDGE_NS = 2 * MAIN20_PERIOD_NS;
	localparam int REL_EDGE_CYC = (REL_EDGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Reference divide ratio for the 1 MHz standby tick
	localparam int REF_DIV = 5;
	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_HCFG = 8'h04;
	localparam logic [7:0] REG_VCFG = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_DEFL = 8'h10;
	// Control bit positions
	localparam int CTRL_LOOP_EN_BIT = 0;
	localparam int CTRL_FB_SHUT_BIT = 1;
	// Defaults ROM contents
	localparam logic [15:0] CTRL_DEFAULT = 16'h0000;
	localparam logic [15:0] HCFG_DEFAULT = 16'h4018;
	localparam logic [15:0] VCFG_DEFAULT = 16'h0020;
	// Reset value of every cleared register
	localparam logic [15:0] ZERO16 = 16'h0000;

	// Reset and initialisation sequence, Gray coded
	typedef enum logic [1:0] {
		SEQ_RESET = 2'b00,
		SEQ_HOLD = 2'b01,
		SEQ_INIT = 2'b11,
		SEQ_RUN = 2'b10
	} drs_state_type;

	// Status word as read by software
	typedef struct packed {
		logic [6:0] reserved;
		logic no_flyback;
		logic sel_line;
		logic hdrive_stop;
		logic rgb_blank;
		logic standby;
		logic power_down;
		logic released;
		drs_state_type seq_state;
	} drs_status_type;
endpackage

/* rtl/drs_top.sv */
/*
 * Reset, initialisation, clock release, standby and tube protection sequencer.
 * Assumes all inputs are synchronous to clk_i, rst_n_i is the standby supply power-on
 * reset, and the line-locked tick arrives as a one-cycle pulse at about 1 MHz.
 */
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
module drs_top #(
	parameter int ADDR_W = 8,
	parameter int DATA_W = 16,
	parameter int STBY_PERIOD = 64
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Reset sources
	input wire logic reset_pin_n_i,
	input wire logic por_standby_supply_i,
	input wire logic por_digital_supply_i,
	input wire logic clock_missing_i,
	// Digital supply below power-down threshold
	input wire logic digital_supply_low_i,
	// Reference clock and line-locked tick
	input wire logic ref_clock_5mhz_i,
	input wire logic line_tick_i,
	// Field timing and protection inputs
	input wire logic vsync_i,
	input wire logic vflyback_i,
	input wire logic safety_low_i,
	input wire logic safety_high_i,
	// Deflection bus payloads
	input wire logic defl_rx_valid_i,
	input wire logic [DATA_W-1:0] defl_rx_data_i,
	input wire logic [7:0] tube_current_i,
	output logic [DATA_W-1:0] defl_tx_data_o,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic [DATA_W-1:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	output logic [DATA_W-1:0] reg_rdata_o,
	// Outputs
	output logic horiz_drive_out_o,
	output logic horiz_drive_out_oe_o,
	output logic ref_clock_out_o,
	output logic rgb_blank_o,
	output logic init_busy_o
);
	// Synchronised power-on reset
	logic rst_meta_ff;
	logic rst_n_sync_ff;
	// Sequence state and timer
	drs_pkg::drs_state_type seq_ff;
	drs_pkg::drs_state_type nxt_seq;
	logic [11:0] seq_timer_ff;
	logic [11:0] nxt_seq_timer;
	logic reset_src;
	logic seq_clear;
	// Registers
	logic [DATA_W-1:0] ctrl_ff;
	logic [DATA_W-1:0] hcfg_ff;
	logic [DATA_W-1:0] vcfg_shadow_ff;
	logic [DATA_W-1:0] vcfg_ff;
	logic vcfg_pending_ff;
	logic [DATA_W-1:0] defl_ff;
	logic [DATA_W-1:0] rdata_ff;
	// Reference sampling, divider and release
	logic ref_q_ff;
	logic [2:0] div_cnt_ff;
	logic stby_tick_ff;
	logic [3:0] hi_cnt_ff;
	logic released_ff;
	logic ref_rise;
	logic ref_fall;
	// Power-down filter and extension
	logic [1:0] low_cnt_ff;
	logic [11:0] ext_cnt_ff;
	logic power_down_ff;
	// Horizontal generator
	logic sel_line_ff;
	logic [7:0] hcnt_ff;
	logic hpulse_ff;
	logic htick;
	logic [7:0] hperiod;
	logic [7:0] hwidth;
	// Protection
	logic safe_lo_ff;
	logic safe_hi_ff;
	logic fb_q_ff;
	logic fb_seen_ff;
	logic no_flyback_ff;
	logic fb_fall;
	logic standby;
	logic running;
	logic hdrive_stop;
	drs_pkg::drs_status_type status;

	// Address match used by both the read and the write path
	function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] off);
		addr_is = (a == ADDR_W'(off));
	endfunction

	// Two-flop release of the power-on reset
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_ff <= 1'b0;
			rst_n_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n_sync_ff <= rst_meta_ff;
		end
	end

	// Any source starts the sequence; missing video clock counts too
	assign reset_src = ~reset_pin_n_i | por_standby_supply_i | por_digital_supply_i
		| clock_missing_i;
	assign seq_clear = (seq_ff == drs_pkg::SEQ_RESET);
	assign running = (seq_ff == drs_pkg::SEQ_RUN);

	// Sequence next state, timed on the main clock
	always_comb begin
		nxt_seq = seq_ff;
		nxt_seq_timer = seq_timer_ff + 12'h001;
		case (seq_ff)
			drs_pkg::SEQ_RESET: begin
				nxt_seq_timer = 12'h000;
				if (!reset_src) begin
					nxt_seq = drs_pkg::SEQ_HOLD;
				end
			end
			drs_pkg::SEQ_HOLD: begin
				// Internal reset stays active after release
				if (seq_timer_ff == 12'(drs_pkg::RESET_HOLD_CYC - 1)) begin
					nxt_seq = drs_pkg::SEQ_INIT;
					nxt_seq_timer = 12'h000;
				end
			end
			drs_pkg::SEQ_INIT: begin
				// Host locked out for the initialisation window
				if (seq_timer_ff == 12'(drs_pkg::INIT_WINDOW_CYC - 1)) begin
					nxt_seq = drs_pkg::SEQ_RUN;
					nxt_seq_timer = 12'h000;
				end
			end
			drs_pkg::SEQ_RUN: begin
				nxt_seq_timer = 12'h000;
			end
			default: begin
				nxt_seq = drs_pkg::SEQ_RESET;
				nxt_seq_timer = 12'h000;
			end
		endcase
		// A source going active restarts from the top
		if (reset_src) begin
			nxt_seq = drs_pkg::SEQ_RESET;
			nxt_seq_timer = 12'h000;
		end
	end

	// Sequence state registers
	always_ff @(posedge clk_i or negedge rst_n_sync_ff) begin
		if (!rst_n_sync_ff) begin
			seq_ff <= drs_pkg::SEQ_RESET;
			seq_timer_ff <= 12'h000;
		end else begin
			seq_ff <= nxt_seq;
			seq_timer_ff <= nxt_seq_timer;
		end
	end

	// Control registers: cleared in reset, defaults at hold end, host writes when running
	always_ff @(posedge clk_i or negedge rst_n_sync_ff) begin
		if (!rst_n_sync_ff) begin
			ctrl_ff <= drs_pkg::ZERO16;
			hcfg_ff <= drs_pkg::ZERO16;
		end else if (seq_clear) begin
			ctrl_ff <= drs_pkg::ZERO16;
			hcfg_ff <= drs_pkg::ZERO16;
		end else if (seq_ff == drs_pkg::SEQ_HOLD && nxt_seq == drs_pkg::SEQ_INIT) begin
			ctrl_ff <= drs_pkg::CTRL_DEFAULT;
			hcfg_ff <= drs_pkg::HCFG_DEFAULT;
		end else if (reg_write_i && running) begin
			// Clearing loop enable is the controller's standby request
			if (addr_is(reg_addr_i, drs_pkg::REG_CTRL)) begin
				ctrl_ff <= reg_wdata_i & 16'h0003;
			end
			if (addr_is(reg_addr_i, drs_pkg::REG_HCFG)) begin
				hcfg_ff <= reg_wdata_i;
			end
		end
	end

	// Vsync-latched register: shadow takes defaults or writes, active copy waits for vsync
	always_ff @(posedge clk_i or negedge rst_n_sync_ff) begin
		if (!rst_n_sync_ff) begin
			vcfg_shadow_ff <= drs_pkg::ZERO16;
			vcfg_ff <= drs_pkg::ZERO16;
			vcfg_pending_ff <= 1'b0;
		end else if (seq_clear) begin
			vcfg_shadow_ff <= drs_pkg::ZERO16;
			vcfg_ff <= drs_pkg::ZERO16;
			vcfg_pending_ff <= 1'b0;
		end else begin
			if (seq_ff == drs_pkg::SEQ_HOLD && nxt_seq == drs_pkg::SEQ_INIT) begin
				vcfg_shadow_ff <= drs_pkg::VCFG_DEFAULT;
				vcfg_pending_ff <= 1'b1;
			end else if (reg_write_i && running && addr_is(reg_addr_i, drs_pkg::REG_VCFG)) begin
				vcfg_shadow_ff <= reg_wdata_i;
				vcfg_pending_ff <= 1'b1;
			end else if (vsync_i) begin
				vcfg_pending_ff <= 1'b0;
			end
			// Active copy only moves on vertical sync
			if (vsync_i && vcfg_pending_ff) begin
				vcfg_ff <= vcfg_shadow_ff;
			end
		end
	end

	// Deflection bus: values in from the front end, measurement and status out
	always_ff @(posedge clk_i or negedge rst_n_sync_ff) begin
		if (!rst_n_sync_ff) begin
			defl_ff <= drs_pkg::ZERO16;
			defl_tx_data_o <= drs_pkg::ZERO16;
		end else if (seq_clear) begin
			defl_ff <= drs_pkg::ZERO16;
			defl_tx_data_o <= drs_pkg::ZERO16;
		end else if (running && !standby) begin
			if (defl_rx_valid_i) begin
				defl_ff <= defl_rx_data_i;
			end
			defl_tx_data_o <= {status[9:2], tube_current_i};
		end
	end

	// Read path: data one cycle after the strobe, zero when locked or unmapped
	always_ff @(posedge clk_i or negedge rst_n_sync_ff) begin
		if (!rst_n_sync_ff) begin
			rdata_ff <= drs_pkg::ZERO16;
		end else if (reg_read_i && running) begin
			if (addr_is(reg_addr_i, drs_pkg::REG_CTRL)) begin
				rdata_ff <= ctrl_ff;
			end else if (addr_is(reg_addr_i, drs_pkg::REG_HCFG)) begin
				rdata_ff <= hcfg_ff;
			end else if (addr_is(reg_addr_i, drs_pkg::REG_VCFG)) begin
				rdata_ff <= vcfg_ff;
			end else if (addr_is(reg_addr_i, drs_pkg::REG_STATUS)) begin
				rdata_ff <= status;
			end else if (addr_is(reg_addr_i, drs_pkg::REG_DEFL)) begin
				rdata_ff <= defl_ff;
			end else begin
				rdata_ff <= drs_pkg::ZERO16;
			end
		end else begin
			rdata_ff <= drs_pkg::ZERO16;
		end
	end
	assign reg_rdata_o = rdata_ff;

	// Reference edges
	assign ref_rise = ref_clock_5mhz_i & ~ref_q_ff;
	assign ref_fall = ~ref_clock_5mhz_i & ref_q_ff;

	// Standby divider runs through the reset sequence; only power-on resets it
	always_ff @(posedge clk_i or negedge rst_n_sync_ff) begin
		if (!rst_n_sync_ff) begin
			ref_q_ff <= 1'b0;
			div_cnt_ff <= 3'h0;
			stby_tick_ff <= 1'b0;
		end else begin
			ref_q_ff <= ref_clock_5mhz_i;
			stby_tick_ff <= 1'b0;
			if (ref_rise) begin
				// Divide the reference by five for the 1 MHz tick
				if (div_cnt_ff == 3'(drs_pkg::REF_DIV - 1)) begin
					div_cnt_ff <= 3'h0;
					stby_tick_ff <= 1'b1;
				end else begin
					div_cnt_ff <= div_cnt_ff + 3'h1;
				end
			end
		end
	end
	// Controller clock output follows the reference in every mode
	assign ref_clock_out_o = ref_q_ff;

	// Clock release: a fall after a long enough high phase, counted from a rise or from standby reset release
	always_ff @(posedge clk_i or negedge rst_n_sync_ff) begin
		if (!rst_n_sync_ff) begin
			hi_cnt_ff <= 4'h0;
			released_ff <= 1'b0;
		end else if (por_standby_supply_i) begin
			hi_cnt_ff <= 4'h0;
			released_ff <= 1'b0;
		end else begin
			if (ref_rise) begin
				hi_cnt_ff <= 4'h1;
			end else if (ref_q_ff && hi_cnt_ff != 4'hF) begin
				hi_cnt_ff <= hi_cnt_ff + 4'h1;
			end
			// A high phase counts from a seen rise, or from standby power-on reset release if already high
			if (ref_fall && hi_cnt_ff >= 4'(drs_pkg::REL_EDGE_CYC)) begin
				released_ff <= 1'b1;
			end
		end
	end

	// Power-down: filter short dips, stretch after recovery
	always_ff @(posedge clk_i or negedge rst_n_sync_ff) begin
		if (!rst_n_sync_ff) begin
			low_cnt_ff <= 2'h0;
			ext_cnt_ff <= 12'h000;
			power_down_ff <= 1'b0;
		end else if (digital_supply_low_i) begin
			ext_cnt_ff <= 12'h000;
			if (low_cnt_ff == 2'(drs_pkg::PD_FILTER_CYC - 1)) begin
				power_down_ff <= 1'b1;
			end else begin
				low_cnt_ff <= low_cnt_ff + 2'h1;
			end
		end else begin
			low_cnt_ff <= 2'h0;
			if (power_down_ff) begin
				// Hold for the extension after the supply is back
				if (ext_cnt_ff == 12'(drs_pkg::PD_EXTEND_CYC - 1)) begin
					power_down_ff <= 1'b0;
					ext_cnt_ff <= 12'h000;
				end else begin
					ext_cnt_ff <= ext_cnt_ff + 12'h001;
				end
			end
		end
	end

	// Standby when loop enable is clear or power-down is active
	assign standby = ~ctrl_ff[drs_pkg::CTRL_LOOP_EN_BIT] | power_down_ff;

	// Clock selector: reset and standby force the standby clock, switched on a tick
	always_ff @(posedge clk_i or negedge rst_n_sync_ff) begin
		if (!rst_n_sync_ff) begin
			sel_line_ff <= 1'b0;
		end else if (!running || standby) begin
			sel_line_ff <= 1'b0;
		end else if (stby_tick_ff) begin
			sel_line_ff <= 1'b1;
		end
	end

	// Generator tick and drive shape: fixed half period in standby
	assign htick = sel_line_ff ? line_tick_i : stby_tick_ff;
	assign hperiod = standby ? 8'(STBY_PERIOD) : hcfg_ff[15:8];
	assign hwidth = standby ? 8'(STBY_PERIOD / 2) : hcfg_ff[7:0];

	// Drive counter keeps its phase across a changeover, so one phase may stretch
	always_ff @(posedge clk_i or negedge rst_n_sync_ff) begin
		if (!rst_n_sync_ff) begin
			hcnt_ff <= 8'h00;
			hpulse_ff <= 1'b0;
		end else if (!released_ff) begin
			hcnt_ff <= 8'h00;
			hpulse_ff <= 1'b0;
		end else if (htick) begin
			if (hcnt_ff >= hperiod - 8'h01) begin
				hcnt_ff <= 8'h00;
			end else begin
				hcnt_ff <= hcnt_ff + 8'h01;
			end
			hpulse_ff <= (hcnt_ff < hwidth);
		end
	end

	// Safety comparator flags taken on the main clock
	always_ff @(posedge clk_i or negedge rst_n_sync_ff) begin
		if (!rst_n_sync_ff) begin
			safe_lo_ff <= 1'b0;
			safe_hi_ff <= 1'b0;
		end else begin
			safe_lo_ff <= safety_low_i;
			safe_hi_ff <= safety_high_i;
		end
	end

	// Flyback watch: one falling edge per field, else blank the next field
	assign fb_fall = ~vflyback_i & fb_q_ff;
	always_ff @(posedge clk_i or negedge rst_n_sync_ff) begin
		if (!rst_n_sync_ff) begin
			fb_q_ff <= 1'b0;
			fb_seen_ff <= 1'b0;
			no_flyback_ff <= 1'b0;
		end else if (seq_clear) begin
			fb_q_ff <= 1'b0;
			fb_seen_ff <= 1'b0;
			no_flyback_ff <= 1'b0;
		end else begin
			fb_q_ff <= vflyback_i;
			if (vsync_i) begin
				// An edge in the boundary cycle belongs to the new field: set wins over clear
				no_flyback_ff <= ~fb_seen_ff;
				fb_seen_ff <= fb_fall;
			end else if (fb_fall) begin
				fb_seen_ff <= 1'b1;
			end
		end
	end

	// Drive stop above upper threshold, unavailable in standby
	assign hdrive_stop = ~standby & safe_hi_ff;

	// Open-drain drive: pull low during the pulse once released
	assign horiz_drive_out_o = 1'b0;
	assign horiz_drive_out_oe_o = released_ff & hpulse_ff & ~hdrive_stop;

	// RGB blanking from protection, flyback option, standby and sequence
	assign rgb_blank_o = standby | ~running | no_flyback_ff | safe_lo_ff | safe_hi_ff
		| (ctrl_ff[drs_pkg::CTRL_FB_SHUT_BIT] & vflyback_i);
	assign init_busy_o = ~running;

	// Status word
	always_comb begin
		status = '0;
		status.seq_state = seq_ff;
		status.released = released_ff;
		status.power_down = power_down_ff;
		status.standby = standby;
		status.rgb_blank = rgb_blank_o;
		status.hdrive_stop = hdrive_stop;
		status.sel_line = sel_line_ff;
		status.no_flyback = no_flyback_ff;
	end
endmodule // drs_top

/* testbench/drs_partner.sv */
/*
 * Far-side model: front end reference clock, line-locked tick and field timing.
 * Assumes clk_i at 50 MHz; every output changes just after a rising edge.
 */
`timescale 1ns/100ps
module drs_partner (
	input wire logic clk_i,
	input wire logic ref_en_i,
	input wire logic fly_en_i,
	output logic ref_o,
	output logic tick_o,
	output logic vsync_o,
	output logic fly_o
);
	// Line and field phase counters
	int unsigned ph = 0;
	int unsigned fc = 0;
	// Outputs start quiet
	initial begin
		{ref_o, tick_o, vsync_o, fly_o} = 4'h0;
	end
	// Timing generators
	always @(posedge clk_i) begin
		ph <= (ph == 49) ? 0 : ph + 1;
		fc <= (fc == 999) ? 0 : fc + 1;
		// Reference at 5 MHz, stands low while withheld
		ref_o <= ref_en_i && ((ph % 10) < 5);
		// Line tick near 1 MHz
		tick_o <= (ph == 0);
		// Field boundary pulse
		vsync_o <= (fc == 0);
		// Flyback falls once per field unless withheld
		fly_o <= (fc < 50) || (!fly_en_i && fly_o);
	end
endmodule // drs_partner

/* testbench/drs_monitor.sv */
/*
 * Port checker for the reset and standby sequencer, bound to its top module.
 * Assumes every input is synchronous to clk_i and the bench holds resets several cycles.
 */
`timescale 1ns/100ps
module drs_monitor (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic reset_pin_n_i,
	input wire logic por_standby_supply_i,
	input wire logic por_digital_supply_i,
	input wire logic clock_missing_i,
	input wire logic digital_supply_low_i,
	input wire logic ref_clock_5mhz_i,
	input wire logic reg_read_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic horiz_drive_out_oe_o,
	input wire logic ref_clock_out_o,
	input wire logic rgb_blank_o,
	input wire logic init_busy_o
);
	// Hold plus initialisation, less one cycle of slack
	localparam int RUN_MIN = 3199;
	logic src; // Any sequence reset source
	logic [3:0] live_ff; // Edges since power-on reset release
	logic [11:0] quiet_ff; // Cycles with no source active
	logic [2:0] hi_ff; // Length of current reference high run
	logic seen_ff; // Valid reference pulse observed
	assign src = !reset_pin_n_i || por_standby_supply_i || por_digital_supply_i || clock_missing_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// Helper counters
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			live_ff <= 4'h0;
			quiet_ff <= 12'h000;
			hi_ff <= 3'h0;
			seen_ff <= 1'b0;
		end else begin
			live_ff <= {live_ff[2:0], 1'b1};
			// Quiet time restarts on any source
			if (src) begin
				quiet_ff <= 12'h000;
			end else if (quiet_ff != 12'hfff) begin
				quiet_ff <= quiet_ff + 12'h001;
			end
			// High run saturates at seven
			hi_ff <= !ref_clock_5mhz_i ? 3'h0 : (hi_ff == 3'h7) ? hi_ff : hi_ff + 3'h1;
			// Release needs a long enough high phase then a fall
			if (por_standby_supply_i) begin
				seen_ff <= 1'b0;
			end else if (!ref_clock_5mhz_i && hi_ff >= 3'h5) begin
				seen_ff <= 1'b1;
			end
		end
	end
	sequence s_src3;
		src [*3];
	endsequence
	sequence s_low3;
		digital_supply_low_i [*3];
	endsequence
	property p_src_busy;
		s_src3 |=> init_busy_o && rgb_blank_o;
	endproperty
	a_src_busy: assert property (p_src_busy)
		else $error("busy or blank missing during reset");
	property p_busy_hold;
		$fell(init_busy_o) |-> quiet_ff >= RUN_MIN;
	endproperty
	a_busy_hold: assert property (p_busy_hold)
		else $error("initialisation ended too early");
	property p_rose_busy;
		$rose(init_busy_o) |-> src || $past(src);
	endproperty
	a_rose_busy: assert property (p_rose_busy)
		else $error("busy rose with no reset source");
	property p_read_busy;
		init_busy_o && reg_read_i |=> reg_rdata_o == 16'h0000;
	endproperty
	a_read_busy: assert property (p_read_busy)
		else $error("read answered during initialisation");
	property p_read_idle;
		!reg_read_i |=> reg_rdata_o == 16'h0000;
	endproperty
	a_read_idle: assert property (p_read_idle)
		else $error("read data outside answer cycle");
	property p_release;
		!seen_ff && !$past(seen_ff) |-> !horiz_drive_out_oe_o;
	endproperty
	a_release: assert property (p_release)
		else $error("drive active before reference release");
	property p_refout;
		live_ff[3] |-> ref_clock_out_o == $past(ref_clock_5mhz_i);
	endproperty
	a_refout: assert property (p_refout)
		else $error("reference output not following");
	property p_pd_blank;
		s_low3 |-> ##[1:3] rgb_blank_o;
	endproperty
	a_pd_blank: assert property (p_pd_blank)
		else $error("power-down did not force standby");
endmodule // drs_monitor

bind drs_top drs_monitor mon_u (
	.clk_i(clk_i),
	.rst_n_i(rst_n_i),
	.reset_pin_n_i(reset_pin_n_i),
	.por_standby_supply_i(por_standby_supply_i),
	.por_digital_supply_i(por_digital_supply_i),
	.clock_missing_i(clock_missing_i),
	.digital_supply_low_i(digital_supply_low_i),
	.ref_clock_5mhz_i(ref_clock_5mhz_i),
	.reg_read_i(reg_read_i),
	.reg_rdata_o(reg_rdata_o),
	.horiz_drive_out_oe_o(horiz_drive_out_oe_o),
	.ref_clock_out_o(ref_clock_out_o),
	.rgb_blank_o(rgb_blank_o),
	.init_busy_o(init_busy_o)
);

/* testbench/display_reset_standby_seq_bench.sv */
/*
 * Self-checking bench for the sequencer: reset sources, registers, standby drive, protection.
 * Assumes the partner model supplies reference and field timing; STBY_PERIOD is set to 8.
 */
`timescale 1ns/100ps
module display_reset_standby_seq_bench;
	logic clk, rst_n, pin_n, por_s, por_d, ck_miss, sup_low, safe_lo, safe_hi;
	logic drx_v, wr_s, rd_s, ref_en, fly_en, ref5, tick, vs, fly;
	logic oe, dout, refo, blank, busy;
	logic [7:0] addr, tube;
	logic [15:0] wdata, drx_d, rdata, tx, v;
	int errors = 0;
	int checks = 0;
	int cyc = 0;
	int seed = 32'hdb57_cf45;
	int hi, lo, n;
	drs_partner part_u (.clk_i(clk), .ref_en_i(ref_en), .fly_en_i(fly_en), .ref_o(ref5),
		.tick_o(tick), .vsync_o(vs), .fly_o(fly));
	drs_top #(.STBY_PERIOD(8)) dut_u (.clk_i(clk), .rst_n_i(rst_n), .reset_pin_n_i(pin_n),
		.por_standby_supply_i(por_s), .por_digital_supply_i(por_d), .clock_missing_i(ck_miss),
		.digital_supply_low_i(sup_low), .ref_clock_5mhz_i(ref5), .line_tick_i(tick),
		.vsync_i(vs), .vflyback_i(fly), .safety_low_i(safe_lo), .safety_high_i(safe_hi),
		.defl_rx_valid_i(drx_v), .defl_rx_data_i(drx_d), .tube_current_i(tube),
		.defl_tx_data_o(tx), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_write_i(wr_s),
		.reg_read_i(rd_s), .reg_rdata_o(rdata), .horiz_drive_out_o(dout),
		.horiz_drive_out_oe_o(oe), .ref_clock_out_o(refo), .rgb_blank_o(blank),
		.init_busy_o(busy));
	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = !clk;
	end
	// Verdict and end of run
	task automatic results;
		if (errors == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			errors++;
			results;
		end
	end
	// Compare and report
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Advance to just after a rising edge
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		step(1);
		{addr, wdata, wr_s} <= {a, d, 1'b1};
		step(1);
		wr_s <= 1'b0;
	endtask
	// Read and compare the answer cycle
	task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
		step(1);
		{addr, rd_s} <= {a, 1'b1};
		step(1);
		rd_s <= 1'b0;
		chk(rdata, e);
	endtask
	// Expected status word in RUN from its flag bits
	function automatic logic [15:0] stat(input logic [6:0] f);
		return {7'h00, f, 2'b10};
	endfunction
	// Bounded wait for the end of initialisation
	task automatic wait_run;
		n = 0;
		while (busy !== 1'b0 && n < 4000) begin
			step(1);
			n++;
		end
		// A wait that runs out ends the run as a failure
		if (busy !== 1'b0) begin
			errors++;
			$display("MISMATCH %0t initialisation did not end", $time);
			results;
		end
	endtask
	// Bounded wait for a level on a line
	task automatic wait_lvl(ref logic s, input logic l);
		n = 0;
		while (s !== l && n < 2000) begin
			step(1);
			n++;
		end
		// A wait that runs out ends the run as a failure
		if (s !== l) begin
			errors++;
			$display("MISMATCH %0t level never reached", $time);
			results;
		end
	endtask
	initial begin
		{rst_n, por_s, por_d, ck_miss, sup_low, safe_lo, safe_hi, drx_v} = 8'h00;
		{wr_s, rd_s, ref_en, tube, addr, wdata, drx_d} = 0;
		{pin_n, fly_en} = 2'b11;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		// Reference withheld, host locked out
		wr(drs_pkg::REG_CTRL, 16'h0001);
		rdchk(drs_pkg::REG_STATUS, 16'h0000);
		step(300);
		chk(oe, 0);
		chk(dout, 0);
		ref_en <= 1'b1;
		wait_run;
		chk(busy, 0);
		rdchk(drs_pkg::REG_STATUS, stat(7'b0001101));
		rdchk(drs_pkg::REG_CTRL, 16'h0000);
		rdchk(drs_pkg::REG_HCFG, 16'h4018);
		rdchk(drs_pkg::REG_VCFG, 16'h0020);
		// Standby drive: 8 ticks of 50 cycles, half high
		wait_lvl(oe, 0);
		wait_lvl(oe, 1);
		{hi, lo} = 0;
		while (oe === 1'b1 && hi < 2000) begin
			step(1);
			hi++;
		end
		while (oe === 1'b0 && lo < 2000) begin
			step(1);
			lo++;
		end
		chk(16'(hi), 16'h00c8);
		chk(16'(lo), 16'h00c8);
		// Random register traffic and deflection values; deflection input sleeps in standby
		wr(drs_pkg::REG_CTRL, 16'h0001);
		repeat (6) begin
			v = 16'($random(seed));
			wr(drs_pkg::REG_HCFG, {1'b1, v[14:8], 1'b0, v[6:0]});
			rdchk(drs_pkg::REG_HCFG, {1'b1, v[14:8], 1'b0, v[6:0]});
			{drx_d, drx_v} <= {~v, 1'b1};
			step(1);
			drx_v <= 1'b0;
			rdchk(drs_pkg::REG_DEFL, ~v);
		end
		rdchk(8'h14, 16'h0000);
		wr(drs_pkg::REG_CTRL, 16'hfffc);
		rdchk(drs_pkg::REG_CTRL, 16'h0000);
		// Controller moves drive to the line-locked clock
		wr(drs_pkg::REG_CTRL, 16'h0001);
		step(200);
		rdchk(drs_pkg::REG_STATUS, stat(7'b0100001));
		tube <= 8'($random(seed));
		step(4);
		chk(tx, {8'h21, tube});
		// Safety thresholds
		safe_lo <= 1'b1;
		step(4);
		chk(blank, 1);
		safe_hi <= 1'b1;
		step(4);
		rdchk(drs_pkg::REG_STATUS, stat(7'b0111001));
		step(100);
		chk(oe, 0);
		{safe_lo, safe_hi} <= 2'b00;
		step(4);
		chk(blank, 0);
		// Withheld flyback edge
		fly_en <= 1'b0;
		step(2100);
		rdchk(drs_pkg::REG_STATUS, stat(7'b1101001));
		chk(blank, 1);
		fly_en <= 1'b1;
		step(2100);
		chk(blank, 0);
		// Software RGB shutoff during flyback
		for (int k = 3; k >= 1; k -= 2) begin
			wr(drs_pkg::REG_CTRL, 16'(k));
			wait_lvl(fly, 0);
			wait_lvl(fly, 1);
			step(2);
			chk(blank, k == 3);
		end
		// Short dip is filtered, long dip holds power-down
		sup_low <= 1'b1;
		step(2);
		sup_low <= 1'b0;
		rdchk(drs_pkg::REG_STATUS, stat(7'b0100001));
		sup_low <= 1'b1;
		step(10);
		sup_low <= 1'b0;
		rdchk(drs_pkg::REG_STATUS, stat(7'b0001111));
		step(2400);
		rdchk(drs_pkg::REG_STATUS, stat(7'b0001111));
		step(200);
		rdchk(drs_pkg::REG_STATUS, stat(7'b0100001));
		// Each reset source restarts the sequence
		for (int s = 0; s < 4; s++) begin
			{pin_n, por_s, por_d, ck_miss} <= {s != 0, s == 1, s == 2, s == 3};
			step(5);
			chk(busy, 1);
			{pin_n, por_s, por_d, ck_miss} <= 4'h8;
			wait_run;
			chk(busy, 0);
			rdchk(drs_pkg::REG_CTRL, 16'h0000);
			rdchk(drs_pkg::REG_HCFG, 16'h4018);
		end
		results;
	end
endmodule // display_reset_standby_seq_bench
